// >>> design/sfsd_frame_sync.sv
// frame alignment, descrambling and payload PRBS synchroniser
`timescale 1ns/1ns
module sfsd_frame_sync
	import sfsd_pkg::*;
#(
	parameter int ROW_BYTES = 17280,
	parameter int ROWS = 9,
	parameter int OH_BYTES = 576,
	parameter int PRBS_ORDER = 15,
	parameter int PRBS_TAP = 14
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic rxBit,
	input wire logic autoSync,
	output logic frameLock_q,
	output logic payloadSync_q,
	output logic syncLoss_q,
	output logic overrun_q,
	output logic [7:0] byteData,
	output logic byteValid,
	input wire logic byteReady
);
	// ****************************************
	// input synchroniser and position counters
	// ****************************************
	logic rxMeta_q, rxSync_q;
	logic [31:0] alignSh_q;
	logic [2:0] bitCnt_q;
	logic [14:0] colCnt_q;
	logic [3:0] rowCnt_q;
	sfsd_state_t state_q, state_d;

	// the serial line is foreign to clk_sys; only rxSync_q is read
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rxMeta_q <= 1'b0;
			rxSync_q <= 1'b0;
		end else begin
			rxMeta_q <= rxBit;
			rxSync_q <= rxMeta_q;
		end
	end

	// alignment window on raw bits, the first overhead row is never scrambled
	wire [31:0] alignWin = {alignSh_q[30:0], rxSync_q};
	wire alignHit = (alignWin == FAW_WORD);
	wire bitLast = (bitCnt_q == 3'h7);
	wire colLast = (colCnt_q == 15'(ROW_BYTES - 1));
	wire rowLast = (rowCnt_q == 4'(ROWS - 1));
	wire atFawEnd = (rowCnt_q == 4'h0) & (colCnt_q == FAW_END_COL) & bitLast;
	wire rowOneOh = (rowCnt_q == 4'h0) & (colCnt_q < 15'(OH_BYTES));
	wire payloadBit = (colCnt_q >= 15'(OH_BYTES));
	wire huntLoad = (state_q == stHunt) & alignHit;
	wire seedLoad = (rowCnt_q == 4'h0) & (colCnt_q == 15'(OH_BYTES - 1)) & bitLast;

	// hunt re-anchors the counters on the bit after the word
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			alignSh_q <= '0;
			bitCnt_q <= 3'h0;
			colCnt_q <= 15'h0000;
			rowCnt_q <= 4'h0;
		end else begin
			alignSh_q <= alignWin;
			if (huntLoad) begin
				bitCnt_q <= 3'h0;
				colCnt_q <= FAW_END_COL + 15'h0001;
				rowCnt_q <= 4'h0;
			end else begin
				bitCnt_q <= bitCnt_q + 3'h1;
				if (bitLast) colCnt_q <= colLast ? 15'h0000 : colCnt_q + 15'h0001;
				if (bitLast && colLast) rowCnt_q <= rowLast ? 4'h0 : rowCnt_q + 4'h1;
			end
		end
	end

	// ****************************************
	// frame-synchronous descrambler
	// ****************************************
	logic [6:0] scr_q;
	wire descBit = rowOneOh ? rxSync_q : rxSync_q ^ scr_q[6];

	// seeded at the byte following the first overhead row
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) scr_q <= SCR_SEED;
		else if (seedLoad) scr_q <= SCR_SEED;
		else if (!rowOneOh) scr_q <= {scr_q[5:0], scr_q[6] ^ scr_q[5]};
	end

	// ****************************************
	// payload reference and error windows
	// ****************************************
	logic [PRBS_ORDER-1:0] ref_q;
	logic [12:0] winCnt_q, winCnt_d;
	logic [10:0] errCnt_q, errCnt_d;
	wire predBit = ref_q[PRBS_ORDER-1] ^ ref_q[PRBS_TAP-1];
	wire errBit = payloadBit & (predBit ^ descBit);
	wire [10:0] errTot = errCnt_q + {10'h000, errBit};
	wire inLock = (state_q == stPrbsLock);
	wire inSync = (state_q == stSynced);
	wire [12:0] winLast = inSync ? LOSS_WIN_LAST : LOCK_WIN_LAST;
	wire winEnd = payloadBit & (winCnt_q == winLast);
	wire lockOk = inLock & winEnd & (errTot <= LOCK_ERR_MAX);
	wire lossHit = inSync & errBit & (errCnt_q == LOSS_ERR_LAST);
	// reference reloads from the line only while locking; afterwards it free-runs
	wire refReload = inLock;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) ref_q <= '1;
		else if (payloadBit) ref_q <= {ref_q[PRBS_ORDER-2:0], refReload ? descBit : predBit};
	end

	// windows restart on every state change and on each window end
	always_comb begin
		winCnt_d = winCnt_q;
		errCnt_d = errCnt_q;
		if ((state_d != state_q) || winEnd || lossHit) begin
			winCnt_d = 13'h0000;
			errCnt_d = 11'h000;
		end else if (payloadBit && (inLock || inSync)) begin
			winCnt_d = winCnt_q + 13'h0001;
			errCnt_d = errTot;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			winCnt_q <= 13'h0000;
			errCnt_q <= 11'h000;
		end else begin
			winCnt_q <= winCnt_d;
			errCnt_q <= errCnt_d;
		end
	end

	// ****************************************
	// synchronisation state machine
	// ****************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			stHunt: begin
				if (alignHit) state_d = stConfirm;
			end
			stConfirm: begin
				// the word must recur exactly one frame later
				if (atFawEnd) state_d = alignHit ? stPrbsLock : stHunt;
			end
			stPrbsLock: begin
				if (lockOk) state_d = stSynced;
			end
			stSynced: begin
				// with auto sync off errors are still measured, lock is kept
				if (lossHit && autoSync) state_d = stHunt;
			end
		endcase
	end

	// loss is set ahead of any clear, and payload sync follows the next loss value,
	// so a relock raises payload sync on the same edge as a first lock does
	wire syncLoss_d = lossHit | (syncLoss_q & ~lockOk);

	// status flags follow the next state so they line up with it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= stHunt;
			frameLock_q <= 1'b0;
			payloadSync_q <= 1'b0;
			syncLoss_q <= 1'b0;
		end else begin
			state_q <= state_d;
			frameLock_q <= (state_d == stPrbsLock) | (state_d == stSynced);
			payloadSync_q <= (state_d == stSynced) & ~syncLoss_d;
			syncLoss_q <= syncLoss_d;
		end
	end

	// ****************************************
	// byte assembly into the buffer
	// ****************************************
	logic [6:0] byteSh_q;
	wire [7:0] byteNow = {byteSh_q, descBit};
	wire bytePush = bitLast & payloadBit & (inLock | inSync);
	logic bufReady;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			byteSh_q <= 7'h00;
			overrun_q <= 1'b0;
		end else begin
			byteSh_q <= byteNow[6:0];
			// the line cannot be held, so a full buffer is flagged until reset
			if (bytePush && !bufReady) overrun_q <= 1'b1;
		end
	end

	sfsd_pair_buf #(.WIDTH(8)) uBuf (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.inValid(bytePush),
		.inReady_q(bufReady),
		.inData(byteNow),
		.outValid_q(byteValid),
		.outReady(byteReady),
		.head_q(byteData)
	);

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	huntToConfirm_a: assert property (huntLoad |=> state_q == stConfirm)
		else $error("alignment hit did not start confirmation");
	fawBytes_a: assert property (
		alignHit |-> alignWin[31:24] == 8'hF6 && alignWin[7:0] == 8'h28)
		else $error("alignment hit on wrong bytes");
	twoFrame_a: assert property (
		$rose(frameLock_q) |-> $past(state_q) == stConfirm && $past(alignHit))
		else $error("frame lock without second frame");
	lossCount_a: assert property (
		inSync && errBit && errCnt_q == 11'h3FF |=> syncLoss_q)
		else $error("loss not flagged at 1024 errors");
	lockWin_a: assert property (
		$rose(payloadSync_q) |-> $past(errTot) <= 11'h002 && $past(winCnt_q) == 13'h007F)
		else $error("payload sync without clean window");
	lockFail_a: assert property (
		inLock && winEnd && errTot > 11'h002 |=> !payloadSync_q ##1 !payloadSync_q)
		else $error("payload sync despite high error rate");
	freeRun_a: assert property (inSync && !autoSync |=> state_q == stSynced)
		else $error("lock dropped with auto sync off");
	rawRow_a: assert property (rowOneOh |-> descBit == rxSync_q)
		else $error("first overhead row was descrambled");
	lossHunt_a: assert property (
		lossHit && autoSync |=> state_q == stHunt && !payloadSync_q && !frameLock_q)
		else $error("loss did not return to hunt");

	frameLockSeen_c: cover property ($rose(frameLock_q));
	payloadSyncSeen_c: cover property ($rose(payloadSync_q));
	lossSeen_c: cover property (lossHit && autoSync);
	bufFull_c: cover property (bytePush && !bufReady);
endmodule : sfsd_frame_sync

// >>> design/sfsd_pkg.sv
// constants and types of the framed-signal synchroniser
// Overview of operation
// - alignment word is last two A1 bytes followed by first two A2 bytes.
// - A1 bytes are F6, A2 bytes are 28, each run 192 bytes long.
// - frame lock only after the word recurs at its position one frame later.
// - sync loss when 1024 errors fall within an 8192-bit window.
// - after frame lock, lock payload PRBS; 2 or fewer errors in 128 bits.
// - loss above loss threshold, established at or below establishment threshold; code declares loss on reaching 1024 errors.
// - with auto sync off, reference free-runs once locked and is never reloaded.
// - descramble all but first overhead row; search word in raw first row.
package sfsd_pkg;
	// ****************************************
	// framing constants
	// ****************************************
	localparam logic [7:0] A1_BYTE = 8'hF6;
	localparam logic [7:0] A2_BYTE = 8'h28;
	localparam int RUN_BYTES = 192;
	localparam logic [31:0] FAW_WORD = {A1_BYTE, A1_BYTE, A2_BYTE, A2_BYTE};
	// column of the last alignment byte (first A2 column plus one)
	localparam logic [14:0] FAW_END_COL = 15'(RUN_BYTES + 1);
	localparam logic [6:0] SCR_SEED = 7'h7F;
	// ****************************************
	// error-density windows
	// ****************************************
	localparam int LOSS_WIN_BITS = 8192;
	localparam int LOSS_ERR_BITS = 1024;
	localparam int LOCK_WIN_BITS = 128;
	localparam int LOCK_ERR_BITS = 2;
	localparam logic [12:0] LOSS_WIN_LAST = 13'(LOSS_WIN_BITS - 1);
	localparam logic [12:0] LOCK_WIN_LAST = 13'(LOCK_WIN_BITS - 1);
	localparam logic [10:0] LOSS_ERR_LAST = 11'(LOSS_ERR_BITS - 1);
	localparam logic [10:0] LOCK_ERR_MAX = 11'(LOCK_ERR_BITS);
	typedef enum logic [1:0] {stHunt, stConfirm, stPrbsLock, stSynced} sfsd_state_t;
endpackage : sfsd_pkg

// >>> design/sfsd_pair_buf.sv
// two-entry buffer between byte assembly and the byte consumer
`timescale 1ns/1ns
module sfsd_pair_buf
	import sfsd_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady_q,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid_q,
	input wire logic outReady,
	output logic [WIDTH-1:0] head_q
);
	logic [WIDTH-1:0] tail_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	wire push = inValid & inReady_q;
	wire pop = outValid_q & outReady;
	// head takes input when it is empty or being emptied with one entry
	wire headFromIn = push & ((cnt_q == 2'h0) | ((cnt_q == 2'h1) & pop));
	wire headFromTail = pop & (cnt_q == 2'h2);
	wire tailLoad = push & (cnt_q == 2'h1) & ~pop;

	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	// ready and valid are registered so both edges see clean flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 2'h0;
			inReady_q <= 1'b1;
			outValid_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			inReady_q <= (cnt_d != 2'h2);
			outValid_q <= (cnt_d != 2'h0);
		end
	end

	// entry storage
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			head_q <= '0;
			tail_q <= '0;
		end else begin
			if (headFromIn) head_q <= inData;
			else if (headFromTail) head_q <= tail_q;
			if (tailLoad) tail_q <= inData;
		end
	end

	bufNoOver_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		cnt_q != 2'h3) else $error("buffer count out of range");
endmodule : sfsd_pair_buf

// >>> testbench/sfsd_line_model.sv
// line model: framed test signal source with optional payload inversion
`timescale 1ns/1ns
module sfsd_line_model
	import sfsd_pkg::*;
#(
	parameter int ROW_BYTES = 400,
	parameter int ROWS = 2,
	parameter int OH_BYTES = 200
) (
	input wire logic clk_sys,
	input wire logic injErr,
	output logic rxBit
);
	int col = 0;
	int row = 0;
	int bitN = 0;
	logic [6:0] scr = SCR_SEED;
	logic [14:0] prbs = 15'h7FFF;
	logic [7:0] ohByte;
	logic d;
	// ****************************************
	// bit source, msb of each byte first
	// ****************************************
	initial rxBit = 1'b0;
	// raw first overhead row; the only F6F62828 sits at columns 190 to 193
	always @(posedge clk_sys) begin
		if (row == 0 && col < OH_BYTES) begin
			ohByte = (col < RUN_BYTES) ? A1_BYTE : A2_BYTE;
			rxBit <= ohByte[7 - bitN];
		end else begin
			if (row == 0 && col == OH_BYTES && bitN == 0) scr = SCR_SEED;
			d = 1'b0;
			if (col >= OH_BYTES) begin
				// inversion keeps the phase but makes every payload bit wrong
				d = prbs[14] ^ injErr;
				prbs = {prbs[13:0], prbs[14] ^ prbs[13]};
			end
			rxBit <= d ^ scr[6];
			scr = {scr[5:0], scr[6] ^ scr[5]};
		end
		bitN = (bitN + 1) % 8;
		if (bitN == 0) col = (col + 1) % ROW_BYTES;
		if (bitN == 0 && col == 0) row = (row + 1) % ROWS;
	end
endmodule : sfsd_line_model

// >>> testbench/test_sfsd_frame_sync.sv
// self-checking bench for the frame synchroniser
`timescale 1ns/1ns
module test_sfsd_frame_sync
	import sfsd_pkg::*;
;
	localparam int FRAME = 2 * 400 * 8; // cycles of one short test frame
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic rxBit;
	logic autoSync = 1'b1;
	logic injErr = 1'b0;
	logic byteReady = 1'b1;
	logic frameLock_q, payloadSync_q, syncLoss_q, overrun_q, byteValid;
	logic [7:0] byteData;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	always #10 clk_sys = ~clk_sys;
	sfsd_frame_sync #(.ROW_BYTES(400), .ROWS(2), .OH_BYTES(200)) i_sfsd_frame_sync (
		.clk_sys(clk_sys), .rstn(rstn), .rxBit(rxBit), .autoSync(autoSync),
		.frameLock_q(frameLock_q), .payloadSync_q(payloadSync_q),
		.syncLoss_q(syncLoss_q), .overrun_q(overrun_q), .byteData(byteData),
		.byteValid(byteValid), .byteReady(byteReady));
	// the line model's defaults already give the short test frame
	sfsd_line_model i_sfsd_line_model (
		.clk_sys(clk_sys), .injErr(injErr), .rxBit(rxBit));
	// ****************************************
	// helpers
	// ****************************************
	task test_done;
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic pick(input int sel);
		case (sel)
			0: return frameLock_q;
			1: return payloadSync_q;
			2: return syncLoss_q;
			default: return byteValid;
		endcase
	endfunction : pick
	// bounded wait at falling edges, n holds the cycles taken
	task waitSig(input int sel, input logic lvl, input int lim);
		n = 0;
		while (n < lim && pick(sel) !== lvl) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : waitSig
	// ceiling well above the expected run of some 22k cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 100000) begin
			n_mismatch++;
			test_done();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	task t_lock;
		chk(frameLock_q, 0);
		waitSig(0, 1, 20000);
		chk(frameLock_q, 1);
		chk(n > FRAME, 1);
		waitSig(1, 1, 2000);
		chk(payloadSync_q, 1);
		chk(n >= LOCK_WIN_BITS, 1);
		chk(syncLoss_q, 0);
	endtask : t_lock
	task t_bytes;
		logic [31:0] w;
		int k;
		logic ok;
		byteReady = 1'b0;
		repeat (12) @(negedge clk_sys);
		chk(overrun_q, 0);
		byteReady = 1'b1;
		k = 0;
		n = 0;
		while (k < 4 && n < 2000) begin
			if (byteValid === 1'b1) begin
				w = {w[23:0], byteData};
				k++;
			end
			@(negedge clk_sys);
			n++;
		end
		ok = 1'b1;
		for (int j = 15; j < 32; j++) if (w[31 - j] !== (w[46 - j] ^ w[45 - j])) ok = 1'b0;
		chk(ok, 1);
		waitSig(3, 1, 2000);
		byteReady = 1'b0;
		repeat (40) @(negedge clk_sys);
		chk(overrun_q, 1);
		byteReady = 1'b1;
	endtask : t_bytes
	task t_lossAuto;
		injErr = 1'b1;
		waitSig(2, 1, 25000);
		chk(syncLoss_q, 1);
		chk(n >= LOSS_ERR_BITS, 1);
		chk(payloadSync_q, 0);
		chk(frameLock_q, 0);
		injErr = 1'b0;
		waitSig(0, 1, 20000);
		chk(n > FRAME, 1);
		waitSig(1, 1, 2000);
		chk(syncLoss_q, 0);
	endtask : t_lossAuto
	task t_lossManual;
		autoSync = 1'b0;
		injErr = 1'b1;
		waitSig(2, 1, 25000);
		chk(syncLoss_q, 1);
		chk(frameLock_q, 1);
		chk(payloadSync_q, 0);
		injErr = 1'b0;
		repeat (200) @(negedge clk_sys);
		chk(frameLock_q, 1);
	endtask : t_lossManual
	initial begin
		repeat (8) @(negedge clk_sys);
		rstn = 1'b1;
		t_lock();
		t_bytes();
		t_lossAuto();
		t_lossManual();
		test_done();
	end
endmodule : test_sfsd_frame_sync
